// [shared/supervisor_consts.vh]
// Constants for the watchdog and supply supervisor
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH
// ***************************************************
// Register byte addresses
// ***************************************************
`define ADDR_SUPERVISOR_CONTROL 12'h000
`define ADDR_CLOCK_CONTROL      12'h004
`define ADDR_POWER_MODE         12'h008
`define ADDR_TIMED_ACCESS       12'h00C
`define ADDR_IRQ_STATUS         12'h010
`define ADDR_IRQ_MASK           12'h014
`define ADDR_STATE              12'h018
// ***************************************************
// Field positions
// ***************************************************
`define SC_RESTART       0
`define SC_RESET_EN      1
`define SC_RESET_FLAG    2
`define SC_TIMEOUT_FLAG  3
`define SC_WARN_FLAG     4
`define SC_WARN_EN       5
`define SC_POWER_ON      6
`define CK_PERIOD_LO     6
`define CK_PERIOD_HI     7
`define PM_MULT          3
`define PM_DIV_LO        6
`define PM_DIV_HI        7
// ***************************************************
// Reset values and keys
// ***************************************************
`define PM_RESET         8'h80
`define CK_RESET         8'h00
`define TA_KEY1          8'hAA
`define TA_KEY2          8'h55
`define TA_WINDOW        3'h3
`define RESET_FLAG_DELAY 10'h200
`define POWER_UP_COUNT   17'h10000
`define WARN_VECTOR      16'h0033
`define RESET_VECTOR     16'h0000
// Base log2 exponents and per-select step of the watchdog timeout
`define EXP_M1_D0        6'h0F
`define EXP_M0_D0        6'h10
`define EXP_D12          6'h11
`define EXP_D3           6'h19
`define EXP_STEP         6'h03
`endif

// [verilog/timed_access.v]
// Timed-access unlock sequence for protected supervisor bits
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_consts.vh"
module timed_access (
   input  wire       clock_in,
   input  wire       reset_in,
   input  wire       enable_in,
   input  wire       wr_in,
   input  wire [7:0] wdata_in,
   input  wire       consume_in,
   output wire       open_out
);
   reg       key1_r;
   reg [2:0] window_r;
   // Two keys in a row open a short window; any protected write closes it
   always @(posedge clock_in) begin
      if (reset_in) begin
         key1_r   <= 1'b0;
         window_r <= 3'h0;
      end else if (enable_in) begin
         if (consume_in) begin
            window_r <= 3'h0;
            key1_r   <= 1'b0;
         end else if (wr_in && key1_r && wdata_in == `TA_KEY2) begin
            window_r <= `TA_WINDOW;
            key1_r   <= 1'b0;
         end else begin
            // The first key must survive the setup cycle of the next bus write
            if (wr_in)
               key1_r <= (wdata_in == `TA_KEY1);
            if (window_r != 3'h0)
               window_r <= window_r - 3'h1;
         end
      end
   end
   assign open_out = (window_r != 3'h0);
endmodule // timed_access
`default_nettype wire

// [verilog/power_sequencer.v]
// Power-on and power-fail reset sequencing
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_consts.vh"
module power_sequencer #(
   parameter [16:0] POWER_UP_CYCLES = `POWER_UP_COUNT
) (
   input  wire clock_in,
   input  wire reset_in,
   input  wire enable_in,
   input  wire supply_low_in,
   output wire hold_out,
   output reg  power_on_pulse_out
);
   reg [16:0] count_r;
   reg        hold_r;
   // Hold while the supply is low, then count before release
   always @(posedge clock_in) begin
      if (reset_in) begin
         hold_r             <= 1'b1;
         count_r            <= 17'h0;
         power_on_pulse_out <= 1'b0;
      end else if (enable_in) begin
         power_on_pulse_out <= 1'b0;
         if (supply_low_in) begin                 // R11
            hold_r  <= 1'b1;
            count_r <= 17'h0;
         end else if (hold_r) begin
            if (count_r == POWER_UP_CYCLES - 17'h1) begin  // R12
               hold_r             <= 1'b0;
               power_on_pulse_out <= 1'b1;        // R14
            end else
               count_r <= count_r + 17'h1;
         end
      end
   end
   assign hold_out = hold_r;
endmodule // power_sequencer
`default_nettype wire

// [verilog/supervisor.v]
// Watchdog and supply supervisor with APB register access
//
// How it works
// R1: Watchdog counter runs always, no enable.
// R2: Period select from clock control bits 7:6.
// R3: Timeout is base count times eight^select.
// R4: Multiplier and divider alter the base count.
// R5: Clock divide field resets to binary 10.
// R6: Full count sets timeout flag and IRQ status bit 0.
// R7: Reset flag set 512 clocks after timeout.
// R8: Reset flag resets processor when enabled.
// R9: Software restarts dog before timeout expires.
// R10: Protected bits need timed-access unlock first.
// R11: Low supply holds processor in reset.
// R12: Count 65536 clocks after supply recovery.
// R13: Drive reset pin high during supply hold.
// R14: Power-on sets flag; software clears it.
// R15: Enabled warning vectors processor to 0033h.
// R16: Warning flag set regardless; software clears.
// R17: Warning interrupt highest, ignores global enable.
// R18: Restart write zeroes count, reads zero.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_consts.vh"
module supervisor #(
   parameter [16:0] POWER_UP_CYCLES = `POWER_UP_COUNT,
   parameter        COUNT_W         = 36
) (
   input  wire        clock_in,
   input  wire        reset_in,
   input  wire        enable_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   output wire        pready_out,
   output reg  [31:0] prdata_out,
   output wire        pslverr_out,
   input  wire        supply_below_reset_in,
   input  wire        supply_below_warn_in,
   input  wire        global_irq_enable_in,
   input  wire        reset_pin_in,
   output wire        reset_pin_out,
   output wire        reset_pin_oe_out,
   output wire        cpu_reset_out,
   output wire        warn_irq_out,
   output wire [15:0] warn_vector_out,
   output wire        irq_out
);
   // ***************************************************
   // Registers
   // ***************************************************
   reg [7:0]         clock_control_r;
   reg [7:0]         power_mode_reg_r;
   reg               reset_en_r, reset_flag_r, timeout_flag_r;
   reg               warn_flag_r, warn_en_r, power_on_r;
   reg [COUNT_W-1:0] dog_count_r;
   reg               pending_r;
   reg [9:0]         delay_r;
   reg               warn_prev_r;
   reg [2:0]         irq_status_r;
   reg [2:0]         irq_mask_r;
   reg               dog_reset_r;
   wire              hold_w;
   wire              power_on_pulse_w;
   wire              ta_open_w;
   wire              access_w = psel_in && penable_in;
   wire              wr_w     = access_w && pwrite_in;
   wire              wr_sc_w  = wr_w && paddr_in == `ADDR_SUPERVISOR_CONTROL;
   wire              wr_ta_w  = wr_w && paddr_in == `ADDR_TIMED_ACCESS;
   // A protected write is a supervisor control write that lands while the window is open
   wire              prot_ok_w = wr_sc_w && ta_open_w;             // R10
   wire              restart_w = prot_ok_w && pwdata_in[`SC_RESTART]; // R18
   wire [1:0]        period_w  = clock_control_r[`CK_PERIOD_HI:`CK_PERIOD_LO];
   wire [1:0]        div_w     = power_mode_reg_r[`PM_DIV_HI:`PM_DIV_LO];
   wire              mult_w    = power_mode_reg_r[`PM_MULT];
   reg  [5:0]        base_exp_w;
   wire [5:0]        exp_w;
   wire              full_w;
   wire              warn_rise_w;
   wire [2:0]        events_w;
   // ***************************************************
   // Helpers
   // ***************************************************
   timed_access timed_access_i (
      .clock_in   (clock_in),
      .reset_in   (reset_in),
      .enable_in  (enable_in),
      .wr_in      (wr_ta_w),
      .wdata_in   (pwdata_in[7:0]),
      .consume_in (wr_sc_w && ta_open_w),
      .open_out   (ta_open_w)
   );
   power_sequencer #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) power_sequencer_i (
      .clock_in           (clock_in),
      .reset_in           (reset_in),
      .enable_in          (enable_in),
      .supply_low_in      (supply_below_reset_in),
      .hold_out           (hold_w),
      .power_on_pulse_out (power_on_pulse_w)
   );
   // ***************************************************
   // Timeout selection
   // ***************************************************
   // Base exponent depends on the system clock settings
   always @* begin
      case (div_w)
         2'b00:   base_exp_w = mult_w ? `EXP_M1_D0 : `EXP_M0_D0;  // R4
         2'b11:   base_exp_w = `EXP_D3;
         default: base_exp_w = `EXP_D12;
      endcase
   end
   // Each step of the select adds three to the exponent
   assign exp_w  = base_exp_w + `EXP_STEP * {4'h0, period_w};   // R2 R3
   // Count compared to 2^exp - 1; wider counts never reach a full count early
   assign full_w = (dog_count_r[5:0] == 6'h3F) &&
                   ((dog_count_r & ((({{(COUNT_W-1){1'b0}}, 1'b1}) << exp_w) - 1'b1))
                    == ((({{(COUNT_W-1){1'b0}}, 1'b1}) << exp_w) - 1'b1));
   // ***************************************************
   // Watchdog counter and flags
   // ***************************************************
   // Free-running; a restart, a full count, reset or the supply hold clears it
   always @(posedge clock_in) begin
      if (reset_in || hold_w) begin
         dog_count_r    <= {COUNT_W{1'b0}};
         pending_r      <= 1'b0;
         delay_r        <= 10'h0;
         timeout_flag_r <= 1'b0;
         reset_flag_r   <= 1'b0;
         dog_reset_r    <= 1'b0;
      end else if (enable_in) begin
         dog_reset_r <= 1'b0;
         if (restart_w) begin
            dog_count_r <= {COUNT_W{1'b0}};         // R18
            pending_r   <= 1'b0;
         end else begin
            dog_count_r <= full_w ? {COUNT_W{1'b0}} : dog_count_r + 1'b1;  // R1
            if (full_w) begin
               pending_r <= 1'b1;
               delay_r   <= 10'h0;
            end else if (pending_r) begin
               if (delay_r == `RESET_FLAG_DELAY - 10'h1) begin  // R7
                  pending_r    <= 1'b0;
                  dog_reset_r  <= reset_en_r;        // R8
               end else
                  delay_r <= delay_r + 10'h1;
            end
         end
         // Hardware set wins over a software clear in the same cycle
         if (full_w && !restart_w)
            timeout_flag_r <= 1'b1;                  // R6
         else if (wr_sc_w && !pwdata_in[`SC_TIMEOUT_FLAG])
            timeout_flag_r <= 1'b0;
         if (pending_r && !restart_w && delay_r == `RESET_FLAG_DELAY - 10'h1)
            reset_flag_r <= 1'b1;                    // R7
         else if (wr_sc_w && !pwdata_in[`SC_RESET_FLAG])
            reset_flag_r <= 1'b0;
      end
   end
   // ***************************************************
   // Control registers and supply flags
   // ***************************************************
   assign warn_rise_w = supply_below_warn_in && !warn_prev_r;
   assign events_w    = {warn_rise_w, power_on_pulse_w,
                         full_w && !restart_w};
   // Software fields; the divide field starts at binary 10
   always @(posedge clock_in) begin
      if (reset_in) begin
         clock_control_r  <= `CK_RESET;
         power_mode_reg_r <= `PM_RESET;              // R5
         reset_en_r       <= 1'b0;
         warn_en_r        <= 1'b0;
         warn_flag_r      <= 1'b0;
         power_on_r       <= 1'b0;
         warn_prev_r      <= 1'b0;
         irq_status_r     <= 3'h0;
         irq_mask_r       <= 3'h0;
      end else if (enable_in) begin
         warn_prev_r <= supply_below_warn_in;
         if (wr_w && paddr_in == `ADDR_CLOCK_CONTROL)
            clock_control_r <= pwdata_in[7:0];
         if (wr_w && paddr_in == `ADDR_POWER_MODE)
            power_mode_reg_r <= pwdata_in[7:0];
         if (prot_ok_w)
            reset_en_r <= pwdata_in[`SC_RESET_EN];   // R10
         if (wr_sc_w)
            warn_en_r <= pwdata_in[`SC_WARN_EN];
         if (supply_below_warn_in)
            warn_flag_r <= 1'b1;                     // R16
         else if (wr_sc_w && !pwdata_in[`SC_WARN_FLAG])
            warn_flag_r <= 1'b0;
         if (power_on_pulse_w)
            power_on_r <= 1'b1;                      // R14
         else if (wr_sc_w && !pwdata_in[`SC_POWER_ON])
            power_on_r <= 1'b0;
         if (wr_w && paddr_in == `ADDR_IRQ_MASK)
            irq_mask_r <= pwdata_in[2:0];
         // Write one to clear; a new event in the same cycle stays set
         if (wr_w && paddr_in == `ADDR_IRQ_STATUS)
            irq_status_r <= (irq_status_r & ~pwdata_in[2:0]) | events_w;
         else
            irq_status_r <= irq_status_r | events_w;
      end
   end
   // ***************************************************
   // Outputs
   // ***************************************************
   assign cpu_reset_out    = hold_w || dog_reset_r;               // R8 R11
   assign reset_pin_out    = 1'b1;
   assign reset_pin_oe_out = hold_w;                              // R13
   // Not gated by the global enable; irq_out is not gated by it either
   assign warn_irq_out     = warn_en_r && warn_flag_r && !hold_w; // R15 R17
   assign warn_vector_out  = warn_irq_out ? `WARN_VECTOR : `RESET_VECTOR;
   assign irq_out          = |(irq_status_r & irq_mask_r);
   assign pready_out       = 1'b1;
   assign pslverr_out      = 1'b0;
   // Read mux, registered so data comes from flip-flops
   always @(posedge clock_in) begin
      if (reset_in)
         prdata_out <= 32'h0;
      else if (enable_in && psel_in && !penable_in && !pwrite_in) begin
         case (paddr_in)
            `ADDR_SUPERVISOR_CONTROL:
               prdata_out <= {24'h0, 1'b0, power_on_r, warn_en_r, warn_flag_r,
                              timeout_flag_r, reset_flag_r, reset_en_r, 1'b0}; // R18
            `ADDR_CLOCK_CONTROL: prdata_out <= {24'h0, clock_control_r};
            `ADDR_POWER_MODE:    prdata_out <= {24'h0, power_mode_reg_r};
            `ADDR_IRQ_STATUS:    prdata_out <= {29'h0, irq_status_r};
            `ADDR_IRQ_MASK:      prdata_out <= {29'h0, irq_mask_r};
            `ADDR_STATE:         prdata_out <= {28'h0, reset_pin_in, pending_r,
                                                global_irq_enable_in, hold_w};
            default:             prdata_out <= 32'h0;
         endcase
      end
   end
endmodule // supervisor
`default_nettype wire

// [verification/supervisor_props.sv]
// Concurrent checks on the supervisor reset, pin and vector outputs
`timescale 1ns/1ps
`default_nettype none
module supervisor_props #(
   parameter [16:0] POWER_UP_CYCLES = 17'h10000
) (
   input wire logic        clock_in,
   input wire logic        reset_in,
   input wire logic        supply_below_reset_in,
   input wire logic        reset_pin_out,
   input wire logic        reset_pin_oe_out,
   input wire logic        cpu_reset_out,
   input wire logic        warn_irq_out,
   input wire logic [15:0] warn_vector_out
);
   logic [17:0] up_cnt_r;
   // ****************
   // Helper logic
   // ****************
   // Cycles since the supply recovered; saturates so a long run never wraps
   always @(posedge clock_in) begin
      if (reset_in || supply_below_reset_in)
         up_cnt_r <= 18'h00000;
      else if (up_cnt_r != 18'h3FFFF)
         up_cnt_r <= up_cnt_r + 18'h00001;
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);
   sequence s_supply_low; supply_below_reset_in [*3]; endsequence
   sequence s_supply_back; $fell(supply_below_reset_in) ##1 !supply_below_reset_in [*8]; endsequence
   property p_hold_on_low; s_supply_low |-> reset_pin_oe_out && cpu_reset_out; endproperty
   a_hold_on_low: assert property (p_hold_on_low)
      else $error("no reset hold while supply low");
   property p_pin_drive; reset_pin_oe_out |-> reset_pin_out; endproperty
   a_pin_drive: assert property (p_pin_drive)
      else $error("reset pin not driven high during hold");
   property p_release_early; $fell(reset_pin_oe_out) |-> up_cnt_r >= POWER_UP_CYCLES - 17'h00001; endproperty
   a_release_early: assert property (p_release_early)
      else $error("hold released before power-up count");
   property p_kept_after_back; $fell(supply_below_reset_in) |-> reset_pin_oe_out [*8]; endproperty
   a_kept_after_back: assert property (p_kept_after_back)
      else $error("hold dropped right after supply recovery");
   property p_release_late; s_supply_back |-> ##[0:30] !reset_pin_oe_out; endproperty
   a_release_late: assert property (p_release_late)
      else $error("hold not released after power-up count");
   property p_vector; warn_irq_out |-> warn_vector_out == 16'h0033; endproperty
   a_vector: assert property (p_vector)
      else $error("wrong warning vector");
   property p_vector_idle; !warn_irq_out |-> warn_vector_out == 16'h0000; endproperty
   a_vector_idle: assert property (p_vector_idle)
      else $error("vector shown without warning request");
   property p_dog_pulse; cpu_reset_out && !reset_pin_oe_out |=> !cpu_reset_out || reset_pin_oe_out; endproperty
   a_dog_pulse: assert property (p_dog_pulse)
      else $error("watchdog reset longer than one cycle");
   property p_no_warn_in_hold; reset_pin_oe_out |-> !warn_irq_out; endproperty
   a_no_warn_in_hold: assert property (p_no_warn_in_hold)
      else $error("warning request during supply hold");
endmodule // supervisor_props
`default_nettype wire

// [verification/tb_supervisor.sv]
// Self-checking bench for the watchdog and supply supervisor
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_consts.vh"
module tb_supervisor;
   localparam int POWER_UP = 16;
   localparam int DOG_BASE = 32768;
   logic        clock_in, reset_in, psel_in, penable_in, pwrite_in;
   logic        supply_below_reset_in, supply_below_warn_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic        pready_out, pslverr_out, enable_in, reset_pin_out, reset_pin_oe_out, cpu_reset_out;
   logic        warn_irq_out, irq_out;
   logic [15:0] warn_vector_out;
   wire         reset_pin_w;
   int          cyc = 0, t0, n, miscompares = 0, n_compared = 0;
   // Shared reset line: device drives it high, otherwise the pull-down wins
   assign reset_pin_w = reset_pin_oe_out ? reset_pin_out : 1'b0;
   supervisor #(.POWER_UP_CYCLES(17'h00010)) supervisor_i (
      .clock_in(clock_in), .reset_in(reset_in), .enable_in(enable_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
      .supply_below_reset_in(supply_below_reset_in), .supply_below_warn_in(supply_below_warn_in),
      .global_irq_enable_in(1'b0), .reset_pin_in(reset_pin_w), .reset_pin_out(reset_pin_out),
      .reset_pin_oe_out(reset_pin_oe_out), .cpu_reset_out(cpu_reset_out), .warn_irq_out(warn_irq_out),
      .warn_vector_out(warn_vector_out), .irq_out(irq_out));
   // ****************
   // Clock, timeout, tasks
   // ****************
   initial begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end
   // Whole run needs about 67k cycles; anything past 80k is a hang
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Request stays up until pready; release is left to the next call or idle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      do @(posedge clock_in); while (pready_out !== 1'b1);
      rd = prdata_out;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd & m, e);
   endtask
   task automatic idle(input int k);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      repeat (k) @(posedge clock_in);
   endtask
   task automatic unlock;
      apb(1'b1, `ADDR_TIMED_ACCESS, 32'hAA);
      apb(1'b1, `ADDR_TIMED_ACCESS, 32'h55);
   endtask
   task automatic wait_until(input int t);
      while (cyc < t) @(posedge clock_in);
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      reset_in = 1'b1;
      psel_in = 1'b0;
      penable_in = 1'b0;
      pwrite_in = 1'b0;
      paddr_in = 12'h000;
      pwdata_in = 32'h0;
      enable_in = 1'b1;
      supply_below_reset_in = 1'b1;
      supply_below_warn_in = 1'b0;
      repeat (2) @(posedge clock_in);
      reset_in <= 1'b0;
      repeat (20) @(posedge clock_in);
      check(cpu_reset_out, 1'b1);
      check(reset_pin_w, 1'b1);
      rd_chk(`ADDR_STATE, 32'h0F, 32'h09);
      supply_below_reset_in <= 1'b0;
      n = 0;
      while (reset_pin_oe_out !== 1'b0) begin
         @(posedge clock_in);
         n++;
      end
      check(n >= POWER_UP && n <= POWER_UP + 4, 1'b1);
      @(posedge clock_in);
      check(cpu_reset_out, 1'b0);
      rd_chk(`ADDR_POWER_MODE, 32'hC0, 32'h80);
      rd_chk(`ADDR_SUPERVISOR_CONTROL, 32'h40, 32'h40);
      rd_chk(12'h020, 32'hFFFFFFFF, 32'h0);
      check(pslverr_out, 1'b0);
      // Released pin falls to the pull-down level and reads back low
      rd_chk(`ADDR_STATE, 32'h0F, 32'h0);
      apb(1'b1, `ADDR_SUPERVISOR_CONTROL, 32'h0);
      rd_chk(`ADDR_SUPERVISOR_CONTROL, 32'h40, 32'h0);
      // Power-on event through status, mask and write-one-to-clear
      apb(1'b1, `ADDR_IRQ_MASK, 32'h02);
      idle(2);
      check(irq_out, 1'b1);
      apb(1'b1, `ADDR_IRQ_STATUS, 32'h02);
      idle(2);
      check(irq_out, 1'b0);
      // Supply warning with its enable off, then on; global enable stays low
      supply_below_warn_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      supply_below_warn_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      rd_chk(`ADDR_SUPERVISOR_CONTROL, 32'h10, 32'h10);
      check(warn_irq_out, 1'b0);
      check(irq_out, 1'b0);
      apb(1'b1, `ADDR_IRQ_MASK, 32'h04);
      apb(1'b1, `ADDR_SUPERVISOR_CONTROL, 32'h30);
      idle(2);
      check(warn_irq_out, 1'b1);
      check(warn_vector_out, 16'h0033);
      check(irq_out, 1'b1);
      apb(1'b1, `ADDR_SUPERVISOR_CONTROL, 32'h20);
      apb(1'b1, `ADDR_IRQ_STATUS, 32'h04);
      idle(2);
      check(warn_irq_out, 1'b0);
      check(irq_out, 1'b0);
      rd_chk(`ADDR_SUPERVISOR_CONTROL, 32'h30, 32'h20);
      // Shortest timeout: multiplier one, divider 00, period 00
      apb(1'b1, `ADDR_POWER_MODE, 32'h08);
      apb(1'b1, `ADDR_CLOCK_CONTROL, 32'h00);
      apb(1'b1, `ADDR_SUPERVISOR_CONTROL, 32'h02);
      rd_chk(`ADDR_SUPERVISOR_CONTROL, 32'h02, 32'h0);
      unlock();
      apb(1'b1, `ADDR_SUPERVISOR_CONTROL, 32'h03);
      t0 = cyc;
      idle(1);
      rd_chk(`ADDR_SUPERVISOR_CONTROL, 32'h0F, 32'h02);
      wait_until(t0 + DOG_BASE - 64);
      rd_chk(`ADDR_SUPERVISOR_CONTROL, 32'h08, 32'h0);
      wait_until(t0 + DOG_BASE + 32);
      rd_chk(`ADDR_SUPERVISOR_CONTROL, 32'h0C, 32'h08);
      idle(1);
      while (cpu_reset_out !== 1'b1) @(posedge clock_in);
      check(cyc - t0 >= DOG_BASE + 504 && cyc - t0 <= DOG_BASE + 520, 1'b1);
      @(posedge clock_in);
      rd_chk(`ADDR_IRQ_STATUS, 32'h01, 32'h01);
      apb(1'b1, `ADDR_IRQ_STATUS, 32'h01);
      // Period 01 is eight times longer, so nothing fires at the base count
      apb(1'b1, `ADDR_CLOCK_CONTROL, 32'h40);
      unlock();
      // Reset stays enabled: period 01, not the restart, keeps the processor running
      apb(1'b1, `ADDR_SUPERVISOR_CONTROL, 32'h03);
      t0 = cyc;
      idle(1);
      wait_until(t0 + DOG_BASE + 600);
      rd_chk(`ADDR_SUPERVISOR_CONTROL, 32'h0E, 32'h02);
      rd_chk(`ADDR_IRQ_STATUS, 32'h01, 32'h0);
      // Clock enable low: a register write in that time is lost
      enable_in <= 1'b0;
      apb(1'b1, `ADDR_CLOCK_CONTROL, 32'hC0);
      enable_in <= 1'b1;
      rd_chk(`ADDR_CLOCK_CONTROL, 32'hFF, 32'h40);
      idle(1);
      summarize();
   end
endmodule // tb_supervisor
bind supervisor supervisor_props #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) props_i (
   .clock_in(clock_in), .reset_in(reset_in), .supply_below_reset_in(supply_below_reset_in),
   .reset_pin_out(reset_pin_out), .reset_pin_oe_out(reset_pin_oe_out), .cpu_reset_out(cpu_reset_out),
   .warn_irq_out(warn_irq_out), .warn_vector_out(warn_vector_out));
`default_nettype wire
